/* core/pdm_port.sv */
// one port of drive-mode pins with apb registers and edge interrupts
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/100ps
`include "pdm_params.svh"
module pdm_port #(
    parameter int NPINS = 8,
    parameter int NUSB  = 2
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic [NPINS-1:0] pad_in,
    output logic      [NPINS-1:0] pad_out,
    output logic      [NPINS-1:0] pad_oe,
    output logic      [NPINS-1:0] pad_pull_up,
    output logic      [NPINS-1:0] pad_pull_dn,
    output logic      [NPINS-1:0] pad_in_en,
    input  wire logic [NPINS-1:0] dsi_out,
    input  wire logic [NPINS-1:0] dsi_oe,
    output logic      [NPINS-1:0] dsi_in,
    input  wire logic [NUSB-1:0]  usb_pad_in,
    output logic      [NUSB-1:0]  usb_pad_out,
    output logic      [NUSB-1:0]  usb_pad_oe,
    output logic                  port_irq
);
    localparam int NST = NPINS + NUSB;

    // ************************************************
    // reset release
    // ************************************************
    logic rst_a_ff;
    logic rst_n;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_a_ff <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_a_ff <= 1'b1;
            rst_n    <= rst_a_ff;
        end
    end

    // ************************************************
    // apb decode
    // ************************************************
    logic              pready_ff;
    logic              pslverr_ff;
    logic [31:0]       prdata_ff;
    wire               setup    = psel & ~penable;
    wire               wr       = psel & penable & pwrite & pready_ff;
    wire               hit_pin  = (paddr[11:5] == `PDM_PIN_BASE_HI);
    wire [2:0]         pin_idx  = paddr[4:2];
    wire               wr_latch = wr & (paddr == `PDM_OFF_LATCH);
    wire               wr_dm0   = wr & (paddr == `PDM_OFF_DM0);
    wire               wr_dm1   = wr & (paddr == `PDM_OFF_DM1);
    wire               wr_dm2   = wr & (paddr == `PDM_OFF_DM2);
    wire               wr_byp   = wr & (paddr == `PDM_OFF_BYPASS);
    wire               wr_bie   = wr & (paddr == `PDM_OFF_BIDIR);
    wire               wr_ityp  = wr & (paddr == `PDM_OFF_INTTYPE);
    wire               wr_stat  = wr & (paddr == `PDM_OFF_INTSTAT);
    wire               wr_reg   = wr & (paddr == `PDM_OFF_REGOUT);
    wire               wr_usb   = wr & (paddr == `PDM_OFF_USBCTL);
    wire               wr_utyp  = wr & (paddr == `PDM_OFF_USBTYPE);
    wire               mapped   = hit_pin | (paddr[11:6] == 6'h00 && paddr[5:2] <= 4'hB);

    // ************************************************
    // configuration state, port form
    // ************************************************
    logic [NPINS-1:0]   latch_ff;                          // output latch
    logic [NPINS-1:0]   dm0_ff, dm1_ff, dm2_ff;            // drive mode bit planes
    logic [NPINS-1:0]   byp_ff;
    logic [NPINS-1:0]   bie_ff;
    logic [NPINS-1:0]   regout_ff;
    logic [2*NPINS-1:0] ityp_ff;
    logic [NUSB-1:0]    usb_data_ff;
    logic [NUSB-1:0]    usb_oe_ff;
    logic [2*NUSB-1:0]  usb_ityp_ff;
    logic [NST-1:0]     stat_ff;
    logic [NST-1:0]     s1_ff, s2_ff, prev_ff;
    logic [NPINS-1:0]   ps_ff;

    logic [NPINS-1:0]   nxt_latch, nxt_dm0, nxt_dm1, nxt_dm2, nxt_byp, nxt_bie;
    logic [2*NPINS-1:0] nxt_ityp;
    logic [NST-1:0]     ev, nxt_stat, clr, sync_val;
    logic [31:0]        pin_word [NPINS];
    logic [NPINS-1:0]   d_out, d_oe, d_up, d_dn, d_in_en;

    // ************************************************
    // per pin: both register views, drive decode, edges
    // ************************************************
    genvar g;
    generate
        for (g = 0; g < NPINS; g++) begin : g_pin
            wire       wp = wr & hit_pin & (pin_idx == 3'(g));
            wire [1:0] it = ityp_ff[2*g +: 2];
            // port form and pin form write the same flops
            assign nxt_latch[g] = wr_latch ? pwdata[g] : wp ? pwdata[`PDM_PF_DATA] : latch_ff[g];
            assign nxt_dm0[g]   = wr_dm0 ? pwdata[g] : wp ? pwdata[`PDM_PF_DM_LO]   : dm0_ff[g];
            assign nxt_dm1[g]   = wr_dm1 ? pwdata[g] : wp ? pwdata[`PDM_PF_DM_LO+1] : dm1_ff[g];
            assign nxt_dm2[g]   = wr_dm2 ? pwdata[g] : wp ? pwdata[`PDM_PF_DM_LO+2] : dm2_ff[g];
            assign nxt_byp[g]   = wr_byp ? pwdata[g] : wp ? pwdata[`PDM_PF_BYP] : byp_ff[g];
            assign nxt_bie[g]   = wr_bie ? pwdata[g] : wp ? pwdata[`PDM_PF_BIE] : bie_ff[g];
            assign nxt_ityp[2*g +: 2] = wr_ityp ? pwdata[2*g +: 2]
                                      : wp ? pwdata[`PDM_PF_IT_LO +: 2] : it;
            assign pin_word[g] = {23'h0, ps_ff[g], it, bie_ff[g], byp_ff[g],
                                  dm2_ff[g], dm1_ff[g], dm0_ff[g], latch_ff[g]};
            // masked sample: analog mode reads zero
            assign sync_val[g] = s2_ff[g] & d_in_en[g];
            // edge events by interrupt type
            assign ev[g] = ((it == 2'(pdm_pkg::IT_RISING) || it == 2'(pdm_pkg::IT_BOTH))
                            & sync_val[g] & ~prev_ff[g])
                         | ((it == 2'(pdm_pkg::IT_FALLING) || it == 2'(pdm_pkg::IT_BOTH))
                            & ~sync_val[g] & prev_ff[g]);
            pdm_pin_drive u_drv (
                .drive_mode_field ({dm2_ff[g], dm1_ff[g], dm0_ff[g]}),
                .latch_bit        (latch_ff[g]),
                .bypass_bit       (byp_ff[g]),
                .dsi_out          (dsi_out[g]),
                .bidir_bit        (bie_ff[g]),
                .dsi_oe           (dsi_oe[g]),
                .regulated        (regout_ff[g]),
                .pad_out          (d_out[g]),
                .pad_oe           (d_oe[g]),
                .pull_up          (d_up[g]),
                .pull_dn          (d_dn[g]),
                .in_en            (d_in_en[g])
            );
        end
        for (g = 0; g < NUSB; g++) begin : g_usb
            wire [1:0] it = usb_ityp_ff[2*g +: 2];
            assign sync_val[NPINS+g] = s2_ff[NPINS+g];
            assign ev[NPINS+g] = ((it == 2'(pdm_pkg::IT_RISING) || it == 2'(pdm_pkg::IT_BOTH))
                                  & sync_val[NPINS+g] & ~prev_ff[NPINS+g])
                               | ((it == 2'(pdm_pkg::IT_FALLING) || it == 2'(pdm_pkg::IT_BOTH))
                                  & ~sync_val[NPINS+g] & prev_ff[NPINS+g]);
        end
    endgenerate

    // write one to clear; a new event wins over the clear
    assign clr      = wr_stat ? pwdata[NST-1:0] : {NST{1'b0}};
    assign nxt_stat = ev | (stat_ff & ~clr);

    // ************************************************
    // read data
    // ************************************************
    wire [31:0] rd_data =
        hit_pin                       ? pin_word[pin_idx] :
        (paddr == `PDM_OFF_LATCH)     ? 32'(latch_ff) :
        (paddr == `PDM_OFF_STATE)     ? 32'(ps_ff) :
        (paddr == `PDM_OFF_DM0)       ? 32'(dm0_ff) :
        (paddr == `PDM_OFF_DM1)       ? 32'(dm1_ff) :
        (paddr == `PDM_OFF_DM2)       ? 32'(dm2_ff) :
        (paddr == `PDM_OFF_BYPASS)    ? 32'(byp_ff) :
        (paddr == `PDM_OFF_BIDIR)     ? 32'(bie_ff) :
        (paddr == `PDM_OFF_INTTYPE)   ? 32'(ityp_ff) :
        (paddr == `PDM_OFF_INTSTAT)   ? 32'(stat_ff) :
        (paddr == `PDM_OFF_REGOUT)    ? 32'(regout_ff) :
        (paddr == `PDM_OFF_USBCTL)    ? 32'({usb_oe_ff, usb_data_ff}) :
        (paddr == `PDM_OFF_USBTYPE)   ? 32'(usb_ityp_ff) : 32'h0000_0000;

    // ************************************************
    // apb answer: one access cycle, no wait states
    // ************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= setup;
            pslverr_ff <= setup & ~mapped;
            prdata_ff  <= (setup & ~pwrite) ? rd_data : 32'h0000_0000;
        end
    end

    // ************************************************
    // configuration registers
    // ************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_ff    <= {NPINS{1'b0}};
            dm0_ff      <= {NPINS{`PDM_RST_DM & 3'h1}} != 0 ? {NPINS{1'b1}} : {NPINS{1'b0}};
            dm1_ff      <= {NPINS{1'b0}};
            dm2_ff      <= {NPINS{1'b0}};
            byp_ff      <= {NPINS{1'b0}};
            bie_ff      <= {NPINS{1'b0}};
            regout_ff   <= {NPINS{1'b0}};
            ityp_ff     <= {2*NPINS{1'b0}};
            usb_data_ff <= {NUSB{1'b0}};
            usb_oe_ff   <= {NUSB{1'b0}};
            usb_ityp_ff <= {2*NUSB{1'b0}};
        end else begin
            latch_ff <= nxt_latch;
            dm0_ff   <= nxt_dm0;
            dm1_ff   <= nxt_dm1;
            dm2_ff   <= nxt_dm2;
            byp_ff   <= nxt_byp;
            bie_ff   <= nxt_bie;
            ityp_ff  <= nxt_ityp;
            if (wr_reg) begin
                regout_ff <= pwdata[NPINS-1:0];
            end
            if (wr_usb) begin
                usb_data_ff <= pwdata[NUSB-1:0];
                usb_oe_ff   <= pwdata[`PDM_USB_OE_LO +: NUSB];
            end
            if (wr_utyp) begin
                usb_ityp_ff <= pwdata[2*NUSB-1:0];
            end
        end
    end

    // ************************************************
    // input sync, pin state, interrupt status
    // ************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_ff   <= {NST{1'b0}};
            s2_ff   <= {NST{1'b0}};
            prev_ff <= {NST{1'b0}};
            ps_ff   <= {NPINS{1'b0}};
            stat_ff <= {NST{1'b0}};
        end else begin
            s1_ff   <= {usb_pad_in, pad_in};
            s2_ff   <= s1_ff;
            prev_ff <= sync_val;
            ps_ff   <= sync_val[NPINS-1:0];
            stat_ff <= nxt_stat;
        end
    end

    // ************************************************
    // registered pad and fabric outputs
    // ************************************************
    logic [NPINS-1:0] pad_out_ff, pad_oe_ff, up_ff, dn_ff, in_en_ff;
    logic [NUSB-1:0]  usb_out_ff, usb_oe_pad_ff;
    logic             irq_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pad_out_ff    <= {NPINS{1'b0}};
            pad_oe_ff     <= {NPINS{1'b0}};
            up_ff         <= {NPINS{1'b0}};
            dn_ff         <= {NPINS{1'b0}};
            in_en_ff      <= {NPINS{1'b0}};
            usb_out_ff    <= {NUSB{1'b0}};
            usb_oe_pad_ff <= {NUSB{1'b0}};
            irq_ff        <= 1'b0;
        end else begin
            pad_out_ff    <= d_out;
            pad_oe_ff     <= d_oe;
            up_ff         <= d_up;
            dn_ff         <= d_dn;
            in_en_ff      <= d_in_en;
            usb_out_ff    <= usb_data_ff;
            usb_oe_pad_ff <= usb_oe_ff;
            irq_ff        <= |nxt_stat;
        end
    end

    // output wiring
    assign prdata      = prdata_ff;
    assign pready      = pready_ff;
    assign pslverr     = pslverr_ff;
    assign pad_out     = pad_out_ff;
    assign pad_oe      = pad_oe_ff;
    assign pad_pull_up = up_ff;
    assign pad_pull_dn = dn_ff;
    assign pad_in_en   = in_en_ff;
    assign dsi_in      = ps_ff;
    assign usb_pad_out = usb_out_ff;
    assign usb_pad_oe  = usb_oe_pad_ff;
    assign port_irq    = irq_ff;

    // ************************************************
    // assertions
    // ************************************************
    wire [2:0] mode0 = {dm2_ff[0], dm1_ff[0], dm0_ff[0]};

    a_apb_answer: assert property (@(posedge clk) disable iff (!rst_n)
        setup |=> pready ##1 !pready)
        else $error("apb answer not one cycle after setup");
    a_analog_off: assert property (@(posedge clk) disable iff (!rst_n)
        (mode0 == 3'h0 && !bie_ff[0]) |=> (!pad_in_en[0] && !pad_oe[0] && !ps_ff[0]))
        else $error("analog mode pin not fully off");
    a_digital_in: assert property (@(posedge clk) disable iff (!rst_n)
        (mode0 == 3'h1) |=> (pad_in_en[0] && !pad_oe[0] && !pad_pull_up[0]))
        else $error("digital hi-z pin drives or has no input");
    a_bypass_path: assert property (@(posedge clk) disable iff (!rst_n)
        (mode0 == 3'h6 && byp_ff[0] && !bie_ff[0]) |=> (pad_oe[0] && pad_out[0] == $past(dsi_out[0])))
        else $error("bypassed pin does not follow fabric");
    a_od_low: assert property (@(posedge clk) disable iff (!rst_n)
        (mode0 == 3'h4 && !byp_ff[0] && !bie_ff[0]) |=> (pad_oe[0] == !$past(latch_ff[0])))
        else $error("open drain low enable wrong");
    a_reg_nopull: assert property (@(posedge clk) disable iff (!rst_n)
        (regout_ff[0] && (mode0 == 3'h2 || mode0 == 3'h7)) |=> (!pad_pull_up[0] && !pad_pull_dn[0]))
        else $error("pull offered in regulated mode");
    a_bidir_input: assert property (@(posedge clk) disable iff (!rst_n)
        (bie_ff[0] && !dsi_oe[0]) |=> (!pad_oe[0] && pad_in_en[0]))
        else $error("bidirectional input still drives");
    a_rise_sets: assert property (@(posedge clk) disable iff (!rst_n)
        (ityp_ff[1:0] == 2'h1 && sync_val[0] && !prev_ff[0]) |=> (stat_ff[0] ##[0:1] port_irq))
        else $error("rising edge did not set status");
    a_edge_only: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(stat_ff[0]) |-> $past(sync_val[0]) != $past(prev_ff[0]))
        else $error("status set without an edge");
    a_stat_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        (stat_ff[0] && !(wr_stat && pwdata[0])) |=> stat_ff[0])
        else $error("status bit lost without clear");
    a_port_vector: assert property (@(posedge clk) disable iff (!rst_n)
        port_irq == (|stat_ff))
        else $error("port interrupt differs from status");

    // drive checks: strong mode drives both ways, fabric enable selects output mode
    a_strong_both: assert property (@(posedge clk) disable iff (!rst_n)
        (mode0 == 3'h6 && !bie_ff[0]) |=> pad_oe[0])
        else $error("strong mode pin not driving");
    a_bidir_drive: assert property (@(posedge clk) disable iff (!rst_n)
        (bie_ff[0] && dsi_oe[0] && mode0 == 3'h6) |=> pad_oe[0])
        else $error("bidirectional output not driving");

    // interrupt and usb checks: edge types, clear against a new event, usb pins
    // a new event in the clear cycle must survive, otherwise edges get lost
    a_fall_sets: assert property (@(posedge clk) disable iff (!rst_n)
        (ityp_ff[1:0] == 2'h2 && !sync_val[0] && prev_ff[0]) |=> stat_ff[0])
        else $error("falling edge did not set status");
    a_no_type: assert property (@(posedge clk) disable iff (!rst_n)
        (ityp_ff[1:0] == 2'h0) |-> !ev[0])
        else $error("event with interrupt type none");
    a_clear_w1c: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_stat && pwdata[0] && !ev[0]) |=> !stat_ff[0])
        else $error("status bit not cleared by write one");
    a_event_wins: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_stat && pwdata[0] && ev[0]) |=> stat_ff[0])
        else $error("event lost in clear cycle");
    a_usb_edge: assert property (@(posedge clk) disable iff (!rst_n)
        (usb_ityp_ff[1:0] == 2'h3 && sync_val[NPINS] != prev_ff[NPINS]) |=> stat_ff[NPINS])
        else $error("usb pin edge did not set status");
    a_usb_drive: assert property (@(posedge clk) disable iff (!rst_n)
        wr_usb |=> ##1 (usb_pad_oe == $past(pwdata[`PDM_USB_OE_LO +: NUSB], 2)))
        else $error("usb pin enable not as written");
endmodule // pdm_port

/* core/pdm_params.svh */
// register map, reset values and field positions of the pin drive mode port
`ifndef PDM_PARAMS_SVH
`define PDM_PARAMS_SVH
`define PDM_OFF_LATCH     12'h000
`define PDM_OFF_STATE     12'h004
`define PDM_OFF_DM0       12'h008
`define PDM_OFF_DM1       12'h00C
`define PDM_OFF_DM2       12'h010
`define PDM_OFF_BYPASS    12'h014
`define PDM_OFF_BIDIR     12'h018
`define PDM_OFF_INTTYPE   12'h01C
`define PDM_OFF_INTSTAT   12'h020
`define PDM_OFF_REGOUT    12'h024
`define PDM_OFF_USBCTL    12'h028
`define PDM_OFF_USBTYPE   12'h02C
`define PDM_PIN_BASE_HI   7'h02
`define PDM_RST_DM        3'h0
`define PDM_RST_BYTE      8'h00
`define PDM_PF_DATA       0
`define PDM_PF_DM_LO      1
`define PDM_PF_BYP        4
`define PDM_PF_BIE        5
`define PDM_PF_IT_LO      6
`define PDM_PF_STATE      8
`define PDM_USB_OE_LO     2
`endif

/* core/pdm_pkg.sv */
// types shared by the pin drive mode port
package pdm_pkg;
    typedef enum logic [2:0] {
        DM_HIZ_ANALOG  = 3'h0,
        DM_HIZ_DIGITAL = 3'h1,
        DM_RES_UP      = 3'h2,
        DM_RES_DOWN    = 3'h3,
        DM_OD_LOW      = 3'h4,
        DM_OD_HIGH     = 3'h5,
        DM_STRONG      = 3'h6,
        DM_RES_UPDOWN  = 3'h7
    } pdm_mode_e;
    typedef enum logic [1:0] {
        IT_NONE    = 2'h0,
        IT_RISING  = 2'h1,
        IT_FALLING = 2'h2,
        IT_BOTH    = 2'h3
    } pdm_itype_e;
endpackage

/* core/pdm_pin_drive.sv */
// drive decode for one general purpose pin
`timescale 1ns/100ps
module pdm_pin_drive (
    input  wire logic [2:0] drive_mode_field,
    input  wire logic       latch_bit,
    input  wire logic       bypass_bit,
    input  wire logic       dsi_out,
    input  wire logic       bidir_bit,
    input  wire logic       dsi_oe,
    input  wire logic       regulated,
    output logic            pad_out,
    output logic            pad_oe,
    output logic            pull_up,
    output logic            pull_dn,
    output logic            in_en
);
    // output data source and effective mode
    wire       data_bit = bypass_bit ? dsi_out : latch_bit;
    wire       to_input = bidir_bit & ~dsi_oe;
    wire [2:0] eff_mode = to_input ? 3'h1 : drive_mode_field;
    wire       no_pull  = regulated;

    // ************************************************
    // mode decode
    // ************************************************
    always_comb begin
        pad_out = data_bit;
        pad_oe  = 1'b0;
        pull_up = 1'b0;
        pull_dn = 1'b0;
        in_en   = 1'b1;
        case (pdm_pkg::pdm_mode_e'(eff_mode))
            pdm_pkg::DM_HIZ_ANALOG: begin
                in_en = 1'b0;
            end
            pdm_pkg::DM_HIZ_DIGITAL: begin
                in_en = 1'b1;
            end
            pdm_pkg::DM_RES_UP: begin
                pad_oe  = ~data_bit;
                pull_up = data_bit & ~no_pull;
            end
            pdm_pkg::DM_RES_DOWN: begin
                pad_oe  = data_bit;
                pull_dn = ~data_bit & ~no_pull;
            end
            pdm_pkg::DM_OD_LOW: begin
                pad_oe = ~data_bit;
            end
            pdm_pkg::DM_OD_HIGH: begin
                pad_oe = data_bit;
            end
            pdm_pkg::DM_STRONG: begin
                pad_oe = 1'b1;
            end
            pdm_pkg::DM_RES_UPDOWN: begin
                pull_up = data_bit & ~no_pull;
                pull_dn = ~data_bit & ~no_pull;
            end
            default: begin
                in_en = 1'b0;
            end
        endcase
    end
endmodule // pdm_pin_drive

/* verification/pdm_board.sv */
// board model that feeds the port pins back from the pad controls
`timescale 1ns/100ps
module pdm_board (
    input  wire logic       clk,
    input  wire logic [7:0] pad_out,
    input  wire logic [7:0] pad_oe,
    input  wire logic [7:0] pad_pull_up,
    input  wire logic [7:0] pad_pull_dn,
    input  wire logic [7:0] ext_val,
    input  wire logic       ext_en,
    input  wire logic [1:0] usb_out,
    input  wire logic [1:0] usb_oe,
    input  wire logic [1:0] usb_ext,
    output logic      [7:0] pad_in,
    output logic      [1:0] usb_in
);
    logic flt_ff = 1'b0;
    // a floating line wanders, so a stale level is never read back
    always_ff @(posedge clk) flt_ff <= ~flt_ff;
    // pin level: own driver first, then board source, then pull resistors
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en ? ext_val[i] :
                        pad_pull_up[i] ? 1'b1 : pad_pull_dn[i] ? 1'b0 : flt_ff;
        end
        usb_in = (usb_oe & usb_out) | (~usb_oe & usb_ext);
    end
endmodule // pdm_board

/* verification/testbench.sv */
// self-checking bench for the pin drive mode port
`timescale 1ns/100ps
module testbench;
    logic        clk, nrst, psel, penable, pwrite, pready, pslverr, port_irq, ext_en, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, e, g;
    logic [7:0]  pad_in, pad_out, pad_oe, pu, pd, in_en, dsi_out, dsi_oe, dsi_in, ext, r;
    logic [7:0]  p0, p1, p2;
    logic [2:0]  mm;
    logic [1:0]  usb_in, usb_out, usb_oe, usb_ext, tt;
    int          err_total, tests_run, cyc;
    pdm_port DUT (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pu),
        .pad_pull_dn(pd), .pad_in_en(in_en), .dsi_out(dsi_out), .dsi_oe(dsi_oe),
        .dsi_in(dsi_in), .usb_pad_in(usb_in), .usb_pad_out(usb_out), .usb_pad_oe(usb_oe),
        .port_irq(port_irq));
    pdm_board BRD (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pu),
        .pad_pull_dn(pd), .ext_val(ext), .ext_en(ext_en), .usb_out(usb_out),
        .usb_oe(usb_oe), .usb_ext(usb_ext), .pad_in(pad_in), .usb_in(usb_in));
    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            end_sim();
        end
    end
    task end_sim;
        if (err_total == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready is seen high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clk);
    endtask
    task wait3;
        repeat (3) @(posedge clk);
    endtask
    task setmode(input logic [2:0] m);
        apb(1'b1, 12'h008, {24'h0, {8{m[0]}}});
        apb(1'b1, 12'h00C, {24'h0, {8{m[1]}}});
        apb(1'b1, 12'h010, {24'h0, {8{m[2]}}});
    endtask
    // expected {oe, driven level, pull up, pull down} of one pin
    function automatic logic [3:0] exp_drv(input logic [2:0] m, input logic d);
        case (m)
            3'h2: return d ? 4'h2 : 4'h8;
            3'h3: return d ? 4'hC : 4'h1;
            3'h4: return d ? 4'h0 : 4'h8;
            3'h5: return d ? 4'hC : 4'h0;
            3'h6: return {1'b1, d, 2'b00};
            3'h7: return d ? 4'h2 : 4'h1;
            default: return 4'h0;
        endcase
    endfunction
    // main sequence
    initial begin
        nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
        pwdata = 32'h0; dsi_out = 8'h00; dsi_oe = 8'h00; ext = 8'h00; ext_en = 1'b0;
        usb_ext = 2'h0;
        void'($urandom(89));
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        chk({pad_oe, pu, pd, in_en}, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h0);
        for (int m = 0; m < 8; m++) begin
            r = 8'($urandom);
            mm = 3'(m);
            setmode(mm);
            apb(1'b1, 12'h000, {24'h0, r});
            wait3;
            for (int i = 0; i < 8; i++) begin
                e[4*i+:4] = exp_drv(mm, r[i]);
                g[4*i+:4] = {pad_oe[i], pad_out[i] & pad_oe[i], pu[i], pd[i]};
            end
            chk(g, e);
            if (m < 2) chk({24'h0, in_en}, {24'h0, {8{mm[0]}}});
        end
        setmode(3'h6);
        dsi_out <= 8'($urandom);
        apb(1'b1, 12'h014, 32'hFF);
        wait3;
        chk({24'h0, pad_out}, {24'h0, dsi_out});
        apb(1'b1, 12'h014, 32'h0);
        dsi_oe <= 8'($urandom);
        apb(1'b1, 12'h018, 32'hFF);
        wait3;
        chk({24'h0, pad_oe}, {24'h0, dsi_oe});
        apb(1'b1, 12'h018, 32'h0);
        setmode(3'h7);
        apb(1'b1, 12'h024, 32'hFF);
        wait3;
        chk({16'h0, pu, pd}, 32'h0);
        apb(1'b1, 12'h024, 32'h0);
        // pin form writes seen through the port form planes
        for (int y = 0; y < 8; y++) begin
            mm = 3'($urandom);
            {p2[y], p1[y], p0[y]} = mm;
            apb(1'b1, 12'h040 + 12'(4 * y), {28'h0, mm, 1'b0});
        end
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, {24'h0, p0});
        apb(1'b0, 12'h00C, 32'h0);
        chk(rd, {24'h0, p1});
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, {24'h0, p2});
        // edge interrupts of every type on all pins and usb pins
        setmode(3'h1);
        ext_en <= 1'b1;
        for (int t = 0; t < 4; t++) begin
            tt = 2'(t);
            ext <= 8'h00;
            usb_ext <= 2'h0;
            apb(1'b1, 12'h01C, {16'h0, {8{tt}}});
            apb(1'b1, 12'h02C, {28'h0, {2{tt}}});
            wait3;
            apb(1'b1, 12'h020, 32'h3FF);
            r = 8'($urandom);
            apb(1'b1, 12'h000, {24'h0, ~r});
            ext <= r;
            usb_ext <= r[1:0];
            wait3;
            apb(1'b0, 12'h020, 32'h0);
            chk(rd, tt[0] ? {22'h0, r[1:0], r} : 32'h0);
            chk({31'h0, port_irq}, {31'h0, tt[0] & (|r)});
            apb(1'b0, 12'h004, 32'h0);
            chk({24'h0, rd[7:0]}, {24'h0, r});
            chk({24'h0, dsi_in}, {24'h0, r});
            apb(1'b1, 12'h020, 32'h3FF);
            wait3;
            chk({31'h0, port_irq}, 32'h0);
            ext <= 8'h00;
            usb_ext <= 2'h0;
            wait3;
            apb(1'b0, 12'h020, 32'h0);
            chk(rd, tt[1] ? {22'h0, r[1:0], r} : 32'h0);
            apb(1'b1, 12'h020, 32'h3FF);
        end
        r = 8'($urandom);
        apb(1'b1, 12'h028, {28'h0, r[3:0]});
        wait3;
        chk({28'h0, usb_oe, usb_out & usb_oe}, {28'h0, r[3:2], r[1:0] & r[3:2]});
        setmode(3'h0);
        ext <= 8'hFF;
        wait3;
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'hFFC, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        end_sim();
    end
endmodule // testbench
